// >>> design/ocfh_host.sv
`timescale 1ns/1ns
module ocfh_host
    import ocfh_pkg::*;
#(
    parameter int PERIOD = DEF_PERIOD,
    parameter int HIGH_TIME = DEF_HIGH_TIME,
    parameter int EVENT_LIMIT = DEF_EVENT_LIMIT,
    parameter int HICCUP_PERIODS = DEF_HICCUP_PERIODS,
    parameter int HIGH_LIMIT_PERIODS = DEF_HIGH_LIMIT_PERIODS
) (
    input wire logic clock,
    input wire logic rst,
    ocfh_link_if.host link,
    input wire logic enable,
    input wire logic [1:0] policy,
    output logic running,
    output logic shut_down,
    output logic [CNT_W-1:0] event_count
);
    typedef enum logic [1:0] {
        OCFH_H_WAIT = 2'h0, OCFH_H_RUN = 2'h1, OCFH_H_HICCUP = 2'h3, OCFH_H_OFF = 2'h2
    } ocfh_host_state_t;
    ocfh_host_state_t state_q, state_d;
    logic [1:0] flag_sync_q, flag_sync_d;
    logic flag_prev_q, flag_prev_d;
    logic [CNT_W-1:0] tick_q, tick_d, ev_q, ev_d, per_q, per_d, wait_q, wait_d;
    logic pclk_q, pclk_d, lim_q, lim_d, run_q, run_d, off_q, off_d;
    logic flag_s, flag_rise, end_per;

    assign flag_s = flag_sync_q[1];
    assign flag_rise = flag_s & ~flag_prev_q;
    assign end_per = tick_q == CNT_W'(PERIOD - 1);

    // pulse train, event counting and policy
    always_comb begin
        flag_sync_d = {flag_sync_q[0], link.overcurrent_flag};
        flag_prev_d = flag_s;
        state_d = state_q;
        tick_d = end_per ? '0 : tick_q + 1'b1;
        ev_d = ev_q;
        per_d = per_q;
        wait_d = wait_q;
        pclk_d = 1'h0;
        lim_d = lim_q;
        run_d = 1'h0;
        off_d = 1'h0;
        case (state_q)
            OCFH_H_WAIT: begin
                tick_d = '0;
                per_d = '0;
                lim_d = 1'h1;
                if (enable && !flag_s) state_d = OCFH_H_RUN; // see R3
            end
            OCFH_H_RUN: begin
                run_d = 1'h1;
                pclk_d = tick_d < CNT_W'(HIGH_TIME);
                if (end_per && per_q != CNT_W'(HIGH_LIMIT_PERIODS)) per_d = per_q + 1'b1;
                lim_d = per_q < CNT_W'(HIGH_LIMIT_PERIODS); // see R9
                if (flag_rise) begin
                    ev_d = ev_q + 1'b1;
                    case (policy)
                        POLICY_FIRST: state_d = OCFH_H_OFF; // see R8
                        POLICY_COUNT: if (ev_d >= CNT_W'(EVENT_LIMIT)) state_d = OCFH_H_OFF; // see R7
                        POLICY_HICCUP: state_d = OCFH_H_HICCUP;
                        default: if (ev_d >= CNT_W'(EVENT_LIMIT)) state_d = OCFH_H_HICCUP;
                    endcase
                    if (state_d != OCFH_H_RUN) pclk_d = 1'h0;
                end
                if (state_d == OCFH_H_HICCUP) wait_d = '0;
                if (!enable) state_d = OCFH_H_WAIT;
            end
            OCFH_H_HICCUP: begin
                if (end_per) wait_d = wait_q + 1'b1;
                // retry with pulses: the flag only clears while drives run
                if (wait_q == CNT_W'(HICCUP_PERIODS)) begin
                    state_d = OCFH_H_RUN;
                    tick_d = '0;
                    per_d = '0;
                    lim_d = 1'h1;
                    ev_d = '0;
                end
            end
            OCFH_H_OFF: begin
                off_d = 1'h1;
                if (!enable) begin
                    state_d = OCFH_H_WAIT;
                    ev_d = '0;
                end
            end
            default: state_d = OCFH_H_WAIT;
        endcase
    end

    // registers
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= OCFH_H_WAIT;
            flag_sync_q <= 2'h3;
            flag_prev_q <= 1'h1;
            tick_q <= '0;
            ev_q <= '0;
            per_q <= '0;
            wait_q <= '0;
            pclk_q <= 1'h0;
            lim_q <= 1'h1;
            run_q <= 1'h0;
            off_q <= 1'h0;
        end else begin
            state_q <= state_d;
            flag_sync_q <= flag_sync_d;
            flag_prev_q <= flag_prev_d;
            tick_q <= tick_d;
            ev_q <= ev_d;
            per_q <= per_d;
            wait_q <= wait_d;
            pclk_q <= pclk_d;
            lim_q <= lim_d;
            run_q <= run_d;
            off_q <= off_d;
        end
    end

    assign link.pulse_clk = pclk_q;
    assign link.limit_threshold_input = lim_q;
    assign running = run_q;
    assign shut_down = off_q;
    assign event_count = ev_q;
endmodule : ocfh_host

// >>> design/ocfh_pkg.sv
package ocfh_pkg;
    // host policy selections for overcurrent response
    localparam logic [1:0] POLICY_FIRST = 2'h0;
    localparam logic [1:0] POLICY_COUNT = 2'h1;
    localparam logic [1:0] POLICY_HICCUP = 2'h2;
    localparam logic [1:0] POLICY_HICCUP_AFTER = 2'h3;
    // default counts: period and high time in clock cycles, hiccup and high-limit times in pulse-train periods
    localparam int DEF_PERIOD = 16;
    localparam int DEF_HIGH_TIME = 8;
    localparam int DEF_EVENT_LIMIT = 4;
    localparam int DEF_HICCUP_PERIODS = 64;
    localparam int DEF_HIGH_LIMIT_PERIODS = 16;
    localparam int CNT_W = 16;
    // reset value of the flag: high until supplies are good
    localparam logic FLAG_RESET = 1'h1;
endpackage : ocfh_pkg

// >>> design/ocfh_link_if.sv
`timescale 1ns/1ns
// pins between host controller and pwm device
interface ocfh_link_if;
    logic pulse_clk;            // host pulse train
    logic overcurrent_flag;     // device flag to host
    logic limit_threshold_input; // host selects high (1) or reduced (0) limit
    modport device (input pulse_clk, input limit_threshold_input, output overcurrent_flag);
    modport host (output pulse_clk, output limit_threshold_input, input overcurrent_flag);
endinterface : ocfh_link_if

// >>> design/ocfh_device.sv
`timescale 1ns/1ns
// Summary of operation
// R1: flag stays high until supplies good
// R2: then flag low, pulses acted upon
// R3: host sends no pulses before flag low
// R4: flag clears only while a drive is on
// R5: control high turns drive on
// R6: clear at next pulse rise, current below limit
// R7: host turns off on persistent limiting
// R8: host picks shutdown, count or hiccup
// R9: host may vary limit over time
// R10: overcurrent cuts drives, sets flag high
// R11: pulse low keeps both drives off
module ocfh_device
    import ocfh_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    ocfh_link_if.device link,
    input wire logic supplies_good,
    input wire logic control_in,
    input wire logic over_limit,
    output logic [1:0] gate_drive_output
);
    typedef enum logic [1:0] {OCFH_WAIT = 2'h0, OCFH_RUN = 2'h1} ocfh_dev_state_t;
    ocfh_dev_state_t state_q, state_d;
    logic [1:0] clk_sync_q, clk_sync_d;
    logic [1:0] sup_sync_q, sup_sync_d;
    logic [1:0] ctl_sync_q, ctl_sync_d;
    logic [1:0] ovl_sync_q, ovl_sync_d;
    logic clk_prev_q, clk_prev_d;
    logic phase_q, phase_d;
    logic cut_q, cut_d;
    logic flag_q, flag_d;
    logic arm_q, arm_d;
    logic [1:0] drive_q, drive_d;
    logic clk_s, rise, ovl;

    assign clk_s = clk_sync_q[1];
    assign rise = clk_s & ~clk_prev_q;
    assign ovl = ovl_sync_q[1];

    // next values of synchronisers, sequencing and outputs
    always_comb begin
        clk_sync_d = {clk_sync_q[0], link.pulse_clk};
        sup_sync_d = {sup_sync_q[0], supplies_good};
        ctl_sync_d = {ctl_sync_q[0], control_in};
        ovl_sync_d = {ovl_sync_q[0], over_limit};
        clk_prev_d = clk_s;
        state_d = state_q;
        phase_d = phase_q;
        cut_d = cut_q;
        flag_d = flag_q;
        arm_d = arm_q;
        drive_d = 2'h0;
        case (state_q)
            OCFH_WAIT: begin
                flag_d = 1'h1; // see R1
                arm_d = 1'h0;
                if (sup_sync_q[1]) begin
                    state_d = OCFH_RUN;
                    flag_d = 1'h0; // see R2
                end
            end
            OCFH_RUN: begin
                if (!sup_sync_q[1]) begin
                    state_d = OCFH_WAIT;
                    flag_d = 1'h1;
                end else begin
                    if (rise) begin
                        phase_d = ~phase_q; // push-pull alternation
                        cut_d = 1'h0;
                    end
                    // drive on only while pulse high and control high
                    if (clk_s && ctl_sync_q[1] && !cut_d) begin // see R5, R11
                        drive_d = phase_d ? 2'h2 : 2'h1;
                    end
                    if (ovl && drive_d != 2'h0) begin
                        cut_d = 1'h1; // see R10
                        drive_d = 2'h0;
                        flag_d = 1'h1;
                        arm_d = 1'h0;
                    end else begin
                        // clear waits for the rise after a clean on-time
                        if (rise && arm_q) begin
                            flag_d = 1'h0; // see R6
                            arm_d = 1'h0;
                        end
                        if (drive_q != 2'h0 && !ovl) begin
                            arm_d = 1'h1; // see R4
                        end
                    end
                end
            end
            default: begin
                state_d = OCFH_WAIT;
                flag_d = 1'h1;
                arm_d = 1'h0;
            end
        endcase
    end

    // registers
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= OCFH_WAIT;
            clk_sync_q <= 2'h0;
            sup_sync_q <= 2'h0;
            ctl_sync_q <= 2'h0;
            ovl_sync_q <= 2'h0;
            clk_prev_q <= 1'h0;
            phase_q <= 1'h0;
            cut_q <= 1'h0;
            flag_q <= FLAG_RESET;
            arm_q <= 1'h0;
            drive_q <= 2'h0;
        end else begin
            state_q <= state_d;
            clk_sync_q <= clk_sync_d;
            sup_sync_q <= sup_sync_d;
            ctl_sync_q <= ctl_sync_d;
            ovl_sync_q <= ovl_sync_d;
            clk_prev_q <= clk_prev_d;
            phase_q <= phase_d;
            cut_q <= cut_d;
            flag_q <= flag_d;
            arm_q <= arm_d;
            drive_q <= drive_d;
        end
    end

    assign link.overcurrent_flag = flag_q;
    assign gate_drive_output = drive_q;
endmodule : ocfh_device

// >>> bench/ocfh_checker.sv
`timescale 1ns/1ns
module ocfh_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic pulse_clk,
    input wire logic overcurrent_flag,
    input wire logic limit_threshold_input
);
    logic seen_low_q;
    logic [3:0] hi_age_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // remembers readiness, counts cycles since pulse train was high
    always_ff @(posedge clock) begin
        if (rst) begin
            seen_low_q <= 1'b0;
            hi_age_q <= 4'hf;
        end else begin
            seen_low_q <= seen_low_q | ~overcurrent_flag;
            hi_age_q <= pulse_clk ? 4'h0 : (hi_age_q == 4'hf ? 4'hf : hi_age_q + 4'h1);
        end
    end
    property p_flag_reset; $fell(rst) |-> overcurrent_flag; endproperty
    a_flag_reset: assert property (p_flag_reset) else $error("flag low after reset");
    property p_host_reset; $fell(rst) |-> !pulse_clk && limit_threshold_input; endproperty
    a_host_reset: assert property (p_host_reset) else $error("host idle wrong");
    property p_wait; !seen_low_q |-> !pulse_clk; endproperty
    a_wait: assert property (p_wait) else $error("pulse before ready");
    property p_limit_start; !seen_low_q |-> limit_threshold_input; endproperty
    a_limit_start: assert property (p_limit_start) else $error("limit low at start");
    property p_clear; $fell(overcurrent_flag) && seen_low_q |-> hi_age_q <= 4'ha; endproperty
    a_clear: assert property (p_clear) else $error("flag cleared without pulse");
    property p_set; $rose(overcurrent_flag) |-> hi_age_q <= 4'ha; endproperty
    a_set: assert property (p_set) else $error("flag set outside pulse");
    property p_high; $rose(pulse_clk) |-> ##8 !pulse_clk; endproperty
    a_high: assert property (p_high) else $error("pulse too long");
    property p_low; $fell(pulse_clk) |-> !pulse_clk [*8]; endproperty
    a_low: assert property (p_low) else $error("pulse off time short");
endmodule : ocfh_checker

// >>> bench/tb_overcurrent_flag_handshake.sv
`timescale 1ns/1ns
module tb_overcurrent_flag_handshake;
    import ocfh_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic supplies_good = 1'b0;
    logic control_in = 1'b0;
    logic over_limit = 1'b0;
    logic enable = 1'b0;
    logic [1:0] policy = POLICY_FIRST;
    logic [1:0] drv;
    logic [1:0] d1;
    logic running;
    logic shut_down;
    logic [CNT_W-1:0] event_count;
    int err_count = 0;
    int checks = 0;
    // free running clock
    always #4 clock = ~clock;
    ocfh_link_if link ();
    ocfh_device u_ocfh_device (.clock(clock), .rst(rst), .link(link),
        .supplies_good(supplies_good), .control_in(control_in), .over_limit(over_limit),
        .gate_drive_output(drv));
    ocfh_host #(.HICCUP_PERIODS(4)) u_ocfh_host (.clock(clock), .rst(rst), .link(link),
        .enable(enable), .policy(policy), .running(running), .shut_down(shut_down),
        .event_count(event_count));
    ocfh_checker u_ocfh_checker (.clock(clock), .rst(rst), .pulse_clk(link.pulse_clk),
        .overcurrent_flag(link.overcurrent_flag),
        .limit_threshold_input(link.limit_threshold_input));
    task results;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    task check(input string name, input logic [CNT_W-1:0] seen, input logic [CNT_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    // bounded wait for a rising pulse train edge
    task wait_rise;
        logic prev;
        prev = link.pulse_clk;
        for (int n = 0; n < 200; n++) begin
            @(negedge clock);
            if (link.pulse_clk === 1'b1 && prev === 1'b0) return;
            prev = link.pulse_clk;
        end
        err_count++;
        $display("[ERR] pulse_rise expected 1 seen 0");
        results();
    endtask : wait_rise
    // startup, drive and overcurrent sequence under one policy, with the clear checked for all but POLICY_FIRST
    task run(input logic [1:0] p);
        @(negedge clock);
        rst = 1'b1;
        supplies_good = 1'b0;
        control_in = 1'b0;
        enable = 1'b1;
        policy = p;
        cyc(8);
        rst = 1'b0;
        cyc(20);
        check("flag_wait", link.overcurrent_flag, 1'b1);
        check("pulse_wait", link.pulse_clk, 1'b0);
        check("host_idle", running, 1'b0);
        supplies_good = 1'b1;
        cyc(6);
        check("flag_ready", link.overcurrent_flag, 1'b0);
        wait_rise();
        check("host_running", running, 1'b1);
        cyc(6);
        check("drive_ctrl_low", drv, 2'h0);
        control_in = 1'b1;
        wait_rise();
        cyc(6);
        d1 = drv;
        check("drive_onehot", ^d1, 1'b1);
        cyc(8);
        check("drive_pulse_low", drv, 2'h0);
        wait_rise();
        cyc(6);
        check("drive_alternate", d1 ^ drv, 2'h3);
        wait_rise();
        over_limit = 1'b1;
        cyc(10);
        over_limit = 1'b0;
        control_in = 1'b0;
        check("flag_overcurrent", link.overcurrent_flag, 1'b1);
        check("event_count", event_count, 16'h0001);
        check("shut_down", shut_down, p == POLICY_FIRST);
        check("running_after", running, p == POLICY_COUNT || p == POLICY_HICCUP_AFTER);
        if (p != POLICY_FIRST) begin
            wait_rise();
            cyc(10);
            control_in = 1'b1;
            wait_rise();
            cyc(6);
            check("flag_held", link.overcurrent_flag, 1'b1);
            wait_rise();
            cyc(6);
            check("flag_cleared", link.overcurrent_flag, 1'b0);
        end
        $display("policy %0d test done", p);
    endtask : run
    initial begin
        for (int p = 0; p < 4; p++) run(p[1:0]);
        results();
    end
endmodule : tb_overcurrent_flag_handshake
